// *** common/sdmi_params.svh ***
`ifndef SDMI_PARAMS_SVH
`define SDMI_PARAMS_SVH

// Internal initialization time and the system clock rate
`define SDMI_INIT_TIME_US 500
`define SDMI_SYS_CLK_MHZ  20
`define SDMI_INIT_CYC     (`SDMI_INIT_TIME_US * `SDMI_SYS_CLK_MHZ)

// Mode register select codes on bank bits 1:0
`define SDMI_SEL_MR0 2'h0
`define SDMI_SEL_MR1 2'h1
`define SDMI_SEL_MR2 2'h2
`define SDMI_SEL_MR3 2'h3

// Field positions
`define SDMI_MR0_BL_HI   1
`define SDMI_MR0_BL_LO   0
`define SDMI_MR0_BT      3
`define SDMI_MR0_DLL_RST 8
`define SDMI_MR0_WR_HI   11
`define SDMI_MR0_WR_LO   9
`define SDMI_MR0_PPD     12
`define SDMI_MR1_DLL_DIS 0
`define SDMI_ADDR_AP     10
`define SDMI_ADDR_BC     12

// MR0 reset value and bank count
`define SDMI_MR0_RESET 13'h0000
`define SDMI_BANKS     8

`endif

// *** common/sdmi_pkg.sv ***
`default_nettype none
package sdmi_pkg;

	// Command decoded from select, RAS, CAS and WE
	typedef enum logic [3:0] {
		SDMI_CMD_MRS = 4'h0,
		SDMI_CMD_REF = 4'h1,
		SDMI_CMD_PRE = 4'h2,
		SDMI_CMD_ACT = 4'h3,
		SDMI_CMD_WR  = 4'h4,
		SDMI_CMD_RD  = 4'h5,
		SDMI_CMD_ZQ  = 4'h6,
		SDMI_CMD_NOP = 4'h7,
		SDMI_CMD_DES = 4'h8
	} sdmi_cmd_t;

	// Burst length field of MR0
	typedef enum logic [1:0] {
		SDMI_BL_FIX8 = 2'h0,
		SDMI_BL_OTF  = 2'h1,
		SDMI_BL_FIX4 = 2'h2,
		SDMI_BL_RSVD = 2'h3
	} sdmi_bl_t;

	// Internal initialization states, Gray along the path
	typedef enum logic [1:0] {
		SDMI_ST_HOLD  = 2'h0,
		SDMI_ST_INIT  = 2'h1,
		SDMI_ST_READY = 2'h3
	} sdmi_init_st_t;

endpackage
`default_nettype wire

// *** hw/sdmi_burst.sv ***
`include "sdmi_params.svh"
`default_nettype none
module sdmi_burst (
	// Link clock and synchronised reset
	input  wire logic       ck,
	input  wire logic       rst_ck,
	// Start request
	input  wire logic       start,
	input  wire logic [2:0] start_col,
	input  wire logic       chop,
	input  wire logic       interleave,
	input  wire logic       write,
	// Progress and word order
	output logic            busy,
	output logic            last,
	output logic            burst_write,
	output logic            word_valid,
	output logic [2:0]      col_even,
	output logic [2:0]      col_odd
);
	import sdmi_pkg::*;

	logic       busy_q;
	logic       busy_d;
	logic [1:0] beat_q;
	logic [1:0] beat_d;
	logic [2:0] col_q;
	logic [2:0] col_d;
	logic       chop_q;
	logic       chop_d;
	logic       il_q;
	logic       il_d;
	logic       wr_q;
	logic       valid_q;
	logic [2:0] even_q;
	logic [2:0] odd_q;

	// Column of word i counted from the start column
	function automatic logic [2:0] col_of(input logic [2:0] s, input logic [2:0] i, input logic il);
		logic [1:0] low;
		low = s[1:0] + i[1:0];
		col_of = il ? (s ^ i) : {s[2] ^ i[2], low};
	endfunction

	////////////////////////////////////////////////////////////////
	// Next beat: a new start may land on the last beat
	always_comb begin
		busy_d = busy_q;
		beat_d = beat_q;
		col_d  = col_q;
		chop_d = chop_q;
		il_d   = il_q;
		if (start) begin
			busy_d = 1'b1;
			beat_d = 2'h0;
			col_d  = start_col;
			chop_d = chop;
			il_d   = interleave;
		end else if (busy_q) begin
			busy_d = (beat_q != 2'h3);
			beat_d = beat_q + 2'h1;
		end
	end

	// Burst state, two words per clock
	always_ff @(posedge ck or posedge rst_ck) begin
		if (rst_ck) begin
			busy_q  <= 1'b0;
			beat_q  <= 2'h0;
			col_q   <= 3'h0;
			chop_q  <= 1'b0;
			il_q    <= 1'b0;
			wr_q    <= 1'b0;
			valid_q <= 1'b0;
			even_q  <= 3'h0;
			odd_q   <= 3'h0;
		end else begin
			busy_q  <= busy_d;
			beat_q  <= beat_d;
			col_q   <= col_d;
			chop_q  <= chop_d;
			il_q    <= il_d;
			wr_q    <= start ? write : wr_q;
			valid_q <= busy_d && !(chop_d && beat_d[1]);
			even_q  <= col_of(col_d, {beat_d, 1'b0}, il_d);
			odd_q   <= col_of(col_d, {beat_d, 1'b1}, il_d);
		end
	end

	assign busy        = busy_q;
	assign last        = busy_q && (beat_q == 2'h3);
	assign burst_write = wr_q;
	assign word_valid  = valid_q;
	assign col_even    = even_q;
	assign col_odd     = odd_q;

	////////////////////////////////////////////////////////////////
	sequence s_start8;
		start && !chop;
	endsequence

	a_full_burst: assert property (@(posedge ck) disable iff (rst_ck)
		s_start8 |=> valid_q [*4])
		else $error("eight-beat burst not four clocks of words");

	a_chop_burst: assert property (@(posedge ck) disable iff (rst_ck)
		start && chop ##1 !start |=> valid_q ##1 !valid_q)
		else $error("chopped burst length wrong");

	a_seq_order: assert property (@(posedge ck) disable iff (rst_ck)
		start && !chop && !interleave && start_col == 3'h1
		|=> (even_q == 3'h1 && odd_q == 3'h2) ##1 (even_q == 3'h3 && odd_q == 3'h0))
		else $error("sequential order wrong");

	a_il_order: assert property (@(posedge ck) disable iff (rst_ck)
		start && interleave && start_col == 3'h3 |=> even_q == 3'h3 && odd_q == 3'h2)
		else $error("interleaved order wrong");

endmodule
`default_nettype wire

// *** hw/sdmi_top.sv ***
`include "sdmi_params.svh"
`default_nettype none
module sdmi_top #(
	parameter int unsigned INIT_CYC = `SDMI_INIT_CYC
) (
	// System clock and reset (reset is the inverted device reset pin)
	input  wire logic              sys_clk,
	input  wire logic              reset,
	// Link clock and command pins, registered on ck
	input  wire logic              ck,
	input  wire logic              cke,
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic [2:0]        ba,
	input  wire logic [12:0]       addr,
	input  wire logic              odt,
	// Initialization and termination status
	output logic                   init_done,
	output logic                   cmd_ready,
	output logic                   odt_term_en,
	// Mode register contents
	output logic [3:0]             mr_written,
	output logic                   dll_enabled,
	output logic                   dll_reset_pend,
	output logic                   pd_fast_exit,
	output logic [3:0]             wr_recovery,
	output sdmi_pkg::sdmi_bl_t     burst_len_mode,
	output logic                   burst_interleave,
	// Bank and burst state
	output logic [7:0]             bank_open,
	output logic                   burst_active,
	output logic                   burst_write,
	output logic                   word_valid,
	output logic [2:0]             word_col_even,
	output logic [2:0]             word_col_odd
);
	import sdmi_pkg::*;

	// System domain
	sdmi_init_st_t st_q;
	sdmi_init_st_t st_d;
	logic [31:0]   cnt_q;
	logic          init_done_q;
	// Link domain
	logic          rst_meta_q;
	logic          rst_ck_q;
	logic          init_meta_q;
	logic          init_sync_q;
	logic          cke_seen_q;
	logic          odt_term_q;
	logic [12:0]   mode_register_zero_q;
	logic [3:0]    wr_rec_q;
	logic          dll_en_q;
	logic [3:0]    mr_written_q;
	logic [7:0]    bank_open_q;
	logic          ap_q;
	logic [2:0]    ap_bank_q;
	logic [3:0]    wr_rec_d;
	sdmi_cmd_t     cmd;
	logic          cmd_ok;
	logic          mrs_ok;
	logic          mr0_wr;
	logic          rw_ok;
	logic          chop;
	logic [2:0]    start_col;
	logic          ap_close;
	logic          b_busy;
	logic          b_last;

	////////////////////////////////////////////////////////////////
	// Internal initialization runs on sys_clk so it needs no ck edges
	// Hold cycle plus counting ends at INIT_CYC, so done never lands late
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			SDMI_ST_HOLD:  st_d = SDMI_ST_INIT;
			SDMI_ST_INIT:  st_d = (cnt_q == 32'(INIT_CYC - 2)) ? SDMI_ST_READY : SDMI_ST_INIT;
			SDMI_ST_READY: st_d = SDMI_ST_READY;
			default:       st_d = SDMI_ST_HOLD;
		endcase
	end

	// State register, restarted by every reset, warm or cold
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_q <= SDMI_ST_HOLD;
		end else begin
			st_q <= st_d;
		end
	end

	// Wait counter for the internal initialization time
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 32'h0000_0000;
		end else if (st_q == SDMI_ST_INIT) begin
			cnt_q <= cnt_q + 32'h0000_0001;
		end else begin
			cnt_q <= 32'h0000_0000;
		end
	end

	// Done flag registered from the next state
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			init_done_q <= 1'b0;
		end else begin
			init_done_q <= (st_d == SDMI_ST_READY);
		end
	end

	assign init_done = init_done_q;

	////////////////////////////////////////////////////////////////
	// Reset for the link domain: asserts at once, releases on ck
	always_ff @(posedge ck or posedge reset) begin
		if (reset) begin
			rst_meta_q <= 1'b1;
			rst_ck_q   <= 1'b1;
		end else begin
			rst_meta_q <= 1'b0;
			rst_ck_q   <= rst_meta_q;
		end
	end

	// Done level crosses into ck by two flops
	always_ff @(posedge ck or posedge rst_ck_q) begin
		if (rst_ck_q) begin
			init_meta_q <= 1'b0;
			init_sync_q <= 1'b0;
		end else begin
			init_meta_q <= init_done_q;
			init_sync_q <= init_meta_q;
		end
	end

	assign cmd_ready = init_sync_q;

	////////////////////////////////////////////////////////////////
	// Command decode; nothing is taken before internal init is done
	always_comb begin
		cmd = cs_n ? SDMI_CMD_DES : sdmi_cmd_t'({1'b0, ras_n, cas_n, we_n});
	end

	assign cmd_ok   = init_sync_q && cke;
	assign mrs_ok   = cmd_ok && (cmd == SDMI_CMD_MRS) && !ba[2];
	assign mr0_wr   = mrs_ok && (ba[1:0] == `SDMI_SEL_MR0);
	assign ap_close = ap_q && b_last;

	// CKE seen high once; a new reset is the only way back
	always_ff @(posedge ck or posedge rst_ck_q) begin
		if (rst_ck_q) begin
			cke_seen_q <= 1'b0;
		end else if (cke) begin
			cke_seen_q <= 1'b1;
		end
	end

	// Termination follows ODT from the ck edge that first samples CKE high
	always_ff @(posedge ck or posedge rst_ck_q) begin
		if (rst_ck_q) begin
			odt_term_q <= 1'b0;
		end else begin
			odt_term_q <= (cke_seen_q || cke) && odt;
		end
	end

	assign odt_term_en = odt_term_q;

	////////////////////////////////////////////////////////////////
	// Write recovery code to cycles; zero marks the reserved code
	always_comb begin
		wr_rec_d = 4'h0;
		unique case (addr[`SDMI_MR0_WR_HI:`SDMI_MR0_WR_LO])
			3'h0: wr_rec_d = 4'h0;
			3'h1: wr_rec_d = 4'h5;
			3'h2: wr_rec_d = 4'h6;
			3'h3: wr_rec_d = 4'h7;
			3'h4: wr_rec_d = 4'h8;
			3'h5: wr_rec_d = 4'hA;
			3'h6: wr_rec_d = 4'hC;
			3'h7: wr_rec_d = 4'hE;
		endcase
	end

	// MR0 is stored whole on every write; the DLL reset bit clears itself
	always_ff @(posedge ck or posedge rst_ck_q) begin
		if (rst_ck_q) begin
			mode_register_zero_q <= `SDMI_MR0_RESET;
			wr_rec_q             <= 4'h0;
		end else if (mr0_wr) begin
			mode_register_zero_q <= addr;
			wr_rec_q             <= wr_rec_d;
		end else if (mode_register_zero_q[`SDMI_MR0_DLL_RST]) begin
			mode_register_zero_q[`SDMI_MR0_DLL_RST] <= 1'b0;
		end
	end

	// DLL enable lives in MR1 bit 0, active low; rest of MR1 unused here
	always_ff @(posedge ck or posedge rst_ck_q) begin
		if (rst_ck_q) begin
			dll_en_q <= 1'b0;
		end else if (mrs_ok && ba[1:0] == `SDMI_SEL_MR1) begin
			dll_en_q <= !addr[`SDMI_MR1_DLL_DIS];
		end
	end

	// One bit per mode register, set on its first write after reset
	always_ff @(posedge ck or posedge rst_ck_q) begin
		if (rst_ck_q) begin
			mr_written_q <= 4'h0;
		end else if (mrs_ok) begin
			mr_written_q[ba[1:0]] <= 1'b1;
		end
	end

	assign mr_written       = mr_written_q;
	assign dll_enabled      = dll_en_q;
	assign dll_reset_pend   = mode_register_zero_q[`SDMI_MR0_DLL_RST];
	assign pd_fast_exit     = mode_register_zero_q[`SDMI_MR0_PPD];
	assign wr_recovery      = wr_rec_q;
	assign burst_len_mode   = sdmi_bl_t'(mode_register_zero_q[`SDMI_MR0_BL_HI:`SDMI_MR0_BL_LO]);
	assign burst_interleave = mode_register_zero_q[`SDMI_MR0_BT];

	////////////////////////////////////////////////////////////////
	// Open banks; mode writes never touch them, so array state survives
	for (genvar b = 0; b < `SDMI_BANKS; b++) begin : g_bank
		always_ff @(posedge ck or posedge rst_ck_q) begin
			if (rst_ck_q) begin
				bank_open_q[b] <= 1'b0;
			end else if (cmd_ok && cmd == SDMI_CMD_ACT && ba == 3'(b)) begin
				bank_open_q[b] <= 1'b1;
			end else if (cmd_ok && cmd == SDMI_CMD_PRE && (addr[`SDMI_ADDR_AP] || ba == 3'(b))) begin
				bank_open_q[b] <= 1'b0;
			end else if (ap_close && ap_bank_q == 3'(b)) begin
				bank_open_q[b] <= 1'b0;
			end
		end
	end

	assign bank_open = bank_open_q;

	////////////////////////////////////////////////////////////////
	// Read or write needs an open bank and a free burst slot
	assign rw_ok = cmd_ok && (cmd == SDMI_CMD_RD || cmd == SDMI_CMD_WR) &&
		bank_open_q[ba] && (!b_busy || b_last);

	// Chop choice: fixed from MR0, or A12 low asks for four on the fly
	always_comb begin
		unique case (burst_len_mode)
			SDMI_BL_FIX4: chop = 1'b1;
			SDMI_BL_OTF:  chop = !addr[`SDMI_ADDR_BC];
			default:      chop = 1'b0;
		endcase
	end

	// Writes ignore the low column bits, so they always start aligned
	always_comb begin
		if (cmd == SDMI_CMD_WR) begin
			start_col = chop ? {addr[2], 2'h0} : 3'h0;
		end else begin
			start_col = addr[2:0];
		end
	end

	// Auto precharge closes the bank as its burst ends
	always_ff @(posedge ck or posedge rst_ck_q) begin
		if (rst_ck_q) begin
			ap_q      <= 1'b0;
			ap_bank_q <= 3'h0;
		end else if (rw_ok) begin
			ap_q      <= addr[`SDMI_ADDR_AP];
			ap_bank_q <= ba;
		end else if (b_last) begin
			ap_q      <= 1'b0;
		end
	end

	// Burst sequencer, two words per link clock
	sdmi_burst u_burst (
		.ck          (ck),
		.rst_ck      (rst_ck_q),
		.start       (rw_ok),
		.start_col   (start_col),
		.chop        (chop),
		.interleave  (burst_interleave),
		.write       (cmd == SDMI_CMD_WR),
		.busy        (b_busy),
		.last        (b_last),
		.burst_write (burst_write),
		.word_valid  (word_valid),
		.col_even    (word_col_even),
		.col_odd     (word_col_odd)
	);

	assign burst_active = b_busy;

	////////////////////////////////////////////////////////////////
	sequence s_dll_req;
		mr0_wr && addr[`SDMI_MR0_DLL_RST];
	endsequence

	sequence s_quiet;
		!mr0_wr;
	endsequence

	a_init_wait: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(init_done_q) |-> $past(cnt_q) == 32'(INIT_CYC - 2))
		else $error("internal init ended at the wrong count");

	a_odt_before_cke: assert property (@(posedge ck) disable iff (rst_ck_q)
		!cke_seen_q && !cke |=> !odt_term_q)
		else $error("termination on before CKE registered high");

	a_odt_follows: assert property (@(posedge ck) disable iff (rst_ck_q)
		cke_seen_q && odt |=> odt_term_q)
		else $error("termination not following ODT");

	a_dll_self_clear: assert property (@(posedge ck) disable iff (rst_ck_q)
		s_dll_req ##1 s_quiet |=> !mode_register_zero_q[`SDMI_MR0_DLL_RST])
		else $error("DLL reset bit did not clear itself");

	a_dll_reset_set: assert property (@(posedge ck) disable iff (rst_ck_q)
		s_dll_req |=> mode_register_zero_q[`SDMI_MR0_DLL_RST])
		else $error("DLL reset not taken");

	a_dll_enable: assert property (@(posedge ck) disable iff (rst_ck_q)
		mrs_ok && ba[1:0] == `SDMI_SEL_MR1 |=> dll_en_q == !$past(addr[`SDMI_MR1_DLL_DIS]))
		else $error("DLL enable not from MR1 bit 0");

	a_ba2_ignored: assert property (@(posedge ck) disable iff (rst_ck_q)
		cmd_ok && cmd == SDMI_CMD_MRS && ba[2] |=> $stable(mr_written_q) && $stable(wr_rec_q))
		else $error("mode write with bank bit 2 high was taken");

	a_mr0_capture: assert property (@(posedge ck) disable iff (rst_ck_q)
		mr0_wr |=> mode_register_zero_q[12:9] == $past(addr[12:9]))
		else $error("MR0 fields not stored");

	a_wr_decode: assert property (@(posedge ck) disable iff (rst_ck_q)
		mr0_wr && addr[`SDMI_MR0_WR_HI:`SDMI_MR0_WR_LO] == 3'h5 |=> wr_rec_q == 4'hA)
		else $error("write recovery decode wrong");

	a_rw_needs_act: assert property (@(posedge ck) disable iff (rst_ck_q)
		cmd_ok && cmd == SDMI_CMD_RD && !bank_open_q[ba] && !b_busy |=> !b_busy)
		else $error("burst started on a closed bank");

	a_act_opens: assert property (@(posedge ck) disable iff (rst_ck_q)
		cmd_ok && cmd == SDMI_CMD_ACT |=> bank_open_q[$past(ba)])
		else $error("Active did not open its bank");

	a_mrs_keeps_banks: assert property (@(posedge ck) disable iff (rst_ck_q)
		mrs_ok && !ap_close |=> $stable(bank_open_q))
		else $error("mode write changed bank state");

	a_otf_chop: assert property (@(posedge ck) disable iff (rst_ck_q)
		rw_ok && burst_len_mode == SDMI_BL_OTF && !addr[`SDMI_ADDR_BC] ##1 !rw_ok
		|=> word_valid ##1 !word_valid)
		else $error("on-the-fly chop not honoured");

	a_no_cmd_early: assert property (@(posedge ck) disable iff (rst_ck_q)
		!init_sync_q |=> $stable(mr_written_q) && $stable(bank_open_q))
		else $error("command taken before internal init finished");

endmodule
`default_nettype wire

// *** test/sdmi_ctrl_model.sv ***
`default_nettype none
module sdmi_ctrl_model (
	// Link clock
	input  wire logic        ck,
	// Command and control pins
	output var  logic        cke,
	output var  logic        cs_n,
	output var  logic        ras_n,
	output var  logic        cas_n,
	output var  logic        we_n,
	output var  logic [2:0]  ba,
	output var  logic [12:0] addr,
	output var  logic        odt
);
	timeunit 1ns;
	timeprecision 100ps;
	import sdmi_pkg::*;

	// Generous stand-ins for the mode write gap and the exit waits
	localparam int TMRD  = 4;
	localparam int TWAIT = 6;

	////////////////////////////////////////////////////////////////
	// Clock enable low from time zero, ahead of any reset release
	initial begin
		cke   = 1'b0;
		cs_n  = 1'b1;
		ras_n = 1'b1;
		cas_n = 1'b1;
		we_n  = 1'b1;
		ba    = 3'h0;
		addr  = 13'h0000;
		odt   = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// Deselected lines toggle so a stale value never reads back
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge ck);
			cs_n <= 1'b1;
			ba   <= ~ba;
			addr <= ~addr;
		end
	endtask

	// One command held for one ck cycle, then deselect
	task automatic cmd(input sdmi_cmd_t c, input logic [2:0] b, input logic [12:0] a);
		@(posedge ck);
		cs_n                 <= (c == SDMI_CMD_DES);
		{ras_n, cas_n, we_n} <= c[2:0];
		ba                   <= b;
		addr                 <= a;
		@(posedge ck);
		cs_n <= 1'b1;
		ba   <= ~b;
		addr <= ~a;
	endtask

	// Start-up once the internal wait is over: clock settled, NOP, enable
	task automatic start_init(input logic odt_lvl);
		logic [1:0] sel [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
		odt <= odt_lvl;
		idle(5);
		cmd(SDMI_CMD_NOP, 3'h0, 13'h0000);
		cke <= 1'b1;
		idle(TWAIT);
		foreach (sel[i]) begin
			cmd(SDMI_CMD_MRS, {1'b0, sel[i]}, (sel[i] == 2'h0) ? 13'h0300 : 13'h0000);
			idle(TMRD);
		end
		cmd(SDMI_CMD_ZQ, 3'h0, 13'h0400);
		idle(TWAIT);
	endtask

	// Drop clock enable well before a warm reset is released
	task automatic cke_off();
		@(posedge ck);
		cke <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** test/sdram_init_and_mode_regs_tb.sv ***
`default_nettype none
module sdram_init_and_mode_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import sdmi_pkg::*;

	// Clocks, reset, pins and status
	logic        sys_clk = 1'b0;
	logic        ck      = 1'b0;
	logic        reset   = 1'b1;
	logic        cke, cs_n, ras_n, cas_n, we_n, odt;
	logic [2:0]  ba;
	logic [12:0] addr;
	logic        init_done, cmd_ready, odt_term_en, dll_enabled, dll_reset_pend, pd_fast_exit;
	logic        burst_interleave, burst_active, burst_write, word_valid;
	logic [3:0]  mr_written, wr_recovery;
	sdmi_bl_t    burst_len_mode;
	logic [7:0]  bank_open;
	logic [2:0]  word_col_even, word_col_odd;
	int          fail_count = 0;
	int          n_checks   = 0;
	logic [3:0]  wr_tab [8] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE};

	// Short init count keeps the run brief
	localparam int INIT_CYC = 20;

	////////////////////////////////////////////////////////////////
	sdmi_top #(.INIT_CYC(INIT_CYC)) dut_u (
		.sys_clk(sys_clk), .reset(reset), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .init_done(init_done),
		.cmd_ready(cmd_ready), .odt_term_en(odt_term_en), .mr_written(mr_written),
		.dll_enabled(dll_enabled), .dll_reset_pend(dll_reset_pend), .pd_fast_exit(pd_fast_exit),
		.wr_recovery(wr_recovery), .burst_len_mode(burst_len_mode), .burst_interleave(burst_interleave),
		.bank_open(bank_open), .burst_active(burst_active), .burst_write(burst_write),
		.word_valid(word_valid), .word_col_even(word_col_even), .word_col_odd(word_col_odd)
	);

	sdmi_ctrl_model ctrl_u (
		.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .addr(addr), .odt(odt)
	);

	// Link clock offset in phase from the system clock
	initial forever #25 sys_clk = ~sys_clk;
	initial begin
		#7;
		forever #15 ck = ~ck;
	end

	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			$display("BAD %0t %s", $time, m);
			fail_count++;
		end
	endtask

	// Expected column of word i for start column s
	function automatic logic [2:0] ord(input logic [2:0] s, input logic il, input int i);
		logic [2:0] j;
		j = 3'(i);
		return il ? (s ^ j) : {s[2] ^ j[2], s[1:0] + j[1:0]};
	endfunction

	// Four clocks of a burst; n valid clocks, zero means refused
	task automatic chk_burst(input logic [2:0] s, input logic il, input int n, input logic wr);
		for (int k = 0; k < 4; k++) begin
			#1;
			chk(burst_active, n != 0, "burst active");
			chk(word_valid, k < n, "word valid");
			if (k < n) begin
				chk(word_col_even, ord(s, il, 2 * k), "even column");
				chk(word_col_odd, ord(s, il, 2 * k + 1), "odd column");
				chk(burst_write, wr, "burst kind");
			end
			@(posedge ck);
		end
	endtask

	// Bounded wait; the link side cannot take commands before this
	task automatic wait_ready();
		for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++) begin
			@(posedge ck);
			#1;
		end
		if (cmd_ready !== 1'b1) begin
			$display("BAD %0t ready timeout", $time);
			fail_count++;
			end_of_test();
		end
	endtask

	////////////////////////////////////////////////////////////////
	// Called before the first sys_clk edge after the reset release; times the internal init
	task automatic t_init(input logic odt_lvl);
		int n;
		chk(mr_written, 4'h0, "mode flags after reset");
		chk(init_done, 1'b0, "init done after reset");
		for (n = 0; n < 100 && init_done !== 1'b1; n++) begin
			@(posedge sys_clk);
			#1;
		end
		chk(16'(n), 16'(INIT_CYC), "internal init time");
		wait_ready();
		chk(odt_term_en, 1'b0, "termination before cke");
		ctrl_u.start_init(odt_lvl);
		#1;
		chk(mr_written, 4'hF, "all mode registers");
		chk(dll_enabled, 1'b1, "dll on");
		chk(dll_reset_pend, 1'b0, "dll reset cleared");
		chk(odt_term_en, odt_lvl, "termination after cke");
		$display("t_init done");
	endtask

	// Every field code of MR0, a refused write, then the DLL bit of MR1
	task automatic t_mr0();
		logic [2:0] v;
		for (int i = 0; i < 8; i++) begin
			v = 3'(i);
			ctrl_u.cmd(SDMI_CMD_MRS, 3'h0, {v[1], v, 1'b1, 4'h0, v[0], 1'b0, v[1:0]});
			#1;
			chk(dll_reset_pend, 1'b1, "dll reset set");
			chk(wr_recovery, wr_tab[v], "write recovery");
			chk(burst_len_mode, v[1:0], "burst length");
			chk(burst_interleave, v[0], "burst order");
			chk(pd_fast_exit, v[1], "power-down exit");
			@(posedge ck);
			#1;
			chk(dll_reset_pend, 1'b0, "dll reset self clear");
		end
		ctrl_u.cmd(SDMI_CMD_MRS, 3'h4, 13'h0000);
		@(posedge ck);
		#1;
		chk(wr_recovery, 4'hE, "high bank bit refused");
		ctrl_u.cmd(SDMI_CMD_MRS, 3'h1, 13'h0001);
		@(posedge ck);
		#1;
		chk(dll_enabled, 1'b0, "dll off");
		ctrl_u.cmd(SDMI_CMD_MRS, 3'h1, 13'h0000);
		@(posedge ck);
		#1;
		chk(dll_enabled, 1'b1, "dll on again");
		$display("t_mr0 done");
	endtask

	task automatic t_burst();
		ctrl_u.cmd(SDMI_CMD_MRS, 3'h0, 13'h0200);
		ctrl_u.idle(4);
		ctrl_u.cmd(SDMI_CMD_ACT, 3'h3, 13'h0000);
		@(posedge ck);
		#1;
		chk(bank_open, 8'h08, "bank opened");
		ctrl_u.cmd(SDMI_CMD_RD, 3'h3, 13'h0001);
		chk_burst(3'h1, 1'b0, 4, 1'b0);
		// Write starts at column 0 whatever the pins say; A10 closes the bank
		ctrl_u.cmd(SDMI_CMD_WR, 3'h3, 13'h0405);
		chk_burst(3'h0, 1'b0, 4, 1'b1);
		@(posedge ck);
		#1;
		chk(bank_open, 8'h00, "auto precharge");
		ctrl_u.cmd(SDMI_CMD_RD, 3'h3, 13'h0001);
		chk_burst(3'h0, 1'b0, 0, 1'b0);
		// Fixed chop: a write starts at the half picked by A2
		ctrl_u.cmd(SDMI_CMD_MRS, 3'h0, 13'h0202);
		ctrl_u.idle(4);
		ctrl_u.cmd(SDMI_CMD_ACT, 3'h3, 13'h0000);
		ctrl_u.cmd(SDMI_CMD_WR, 3'h3, 13'h0406);
		chk_burst(3'h4, 1'b0, 2, 1'b1);
		ctrl_u.cmd(SDMI_CMD_MRS, 3'h0, 13'h0209);
		ctrl_u.idle(4);
		ctrl_u.cmd(SDMI_CMD_ACT, 3'h3, 13'h0000);
		ctrl_u.cmd(SDMI_CMD_RD, 3'h3, 13'h0005);
		chk_burst(3'h5, 1'b1, 2, 1'b0);
		ctrl_u.cmd(SDMI_CMD_PRE, 3'h0, 13'h0400);
		@(posedge ck);
		#1;
		chk(bank_open, 8'h00, "precharge all");
		$display("t_burst done");
	endtask

	// Warm reset in mid-run clears the mode state, then start-up again
	task automatic t_warm();
		ctrl_u.cke_off();
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		chk(dll_enabled, 1'b0, "dll after warm reset");
		chk(odt_term_en, 1'b0, "termination in reset");
		t_init(1'b0);
		$display("t_warm done");
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		t_init(1'b1);
		t_mr0();
		t_burst();
		t_warm();
		end_of_test();
	end
endmodule
`default_nettype wire
